// *** include/tdtc_regs.svh ***
// Functional notes
// (RULE_01) Address 70 write loads steering register
// (RULE_02) Address 71 stores where steering line low
// (RULE_03) Host update is seven writes total
// (RULE_04) Steering also drives coarse/fine track lines
// (RULE_05) Address 80 enables write-back comparison
// (RULE_06) Three byte registers per converter side
// (RULE_07) DAC pair summed with three-bit overlap
// (RULE_08) Host moves low MSB before increment
// (RULE_09) Carry-free steps written directly by host
// (RULE_10) Track mode: output follows DAC pair
// (RULE_11) Hold mode keeps previous output as reference
// (RULE_12) Host approximates low DAC MSB first
// (RULE_13) Host returns side to track afterwards
// (RULE_14) Steering bit map: fine 0-3, coarse 4-7
// (RULE_15) Enables active low, hold bits active high
// (RULE_16) Host exercises all 12 low bits
// (RULE_17) Comparator readable while write-back enabled
// (RULE_18) Steered-off register keeps its contents
`ifndef TDTC_REGS_SVH
`define TDTC_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TDTC_IDX_STEER      8'h70
`define TDTC_IDX_DATA       8'h71
`define TDTC_IDX_WBACK      8'h80
`define TDTC_IDX_STATUS     8'h90
`define TDTC_IDX_IRQ_STAT   8'h91
`define TDTC_IDX_IRQ_MASK   8'h92

// ****************************************************************
// Steering byte fields
// ****************************************************************
`define TDTC_ST_FINE_LO     0
`define TDTC_ST_FINE_MID    1
`define TDTC_ST_FINE_HI     2
`define TDTC_ST_FINE_HOLD   3
`define TDTC_ST_COARSE_LO   4
`define TDTC_ST_COARSE_MID  5
`define TDTC_ST_COARSE_HI   6
`define TDTC_ST_COARSE_HOLD 7

// ****************************************************************
// Status and interrupt fields
// ****************************************************************
`define TDTC_SR_CCMP        0
`define TDTC_SR_FCMP        1
`define TDTC_SR_WB          2
`define TDTC_SR_CTRACK      3
`define TDTC_SR_FTRACK      4
`define TDTC_SR_WCNT_LO     5
`define TDTC_IRQ_CCMP       0
`define TDTC_IRQ_FCMP       1
`define TDTC_IRQ_UPD        2
`define TDTC_IRQ_IGN        3

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define TDTC_STEER_RST      8'h00
`define TDTC_IRQ_RST        4'h0
`define TDTC_WB_RST         1'b0
`define TDTC_DATA_WRITES    3'h6
`define TDTC_OVERLAP_SHIFT  9

`endif

// *** include/tdtc_pkg.sv ***
// ****************************************************************
// Types shared by the tuning converter control
// ****************************************************************
package tdtc_pkg;

    typedef enum logic [1:0]
    {
        TDTC_IDLE   = 2'b00,
        TDTC_ANSWER = 2'b01
    } tdtc_bus_state_t;

    typedef logic [7:0]  tdtc_byte_t;
    typedef logic [11:0] tdtc_dac_t;
    typedef logic [21:0] tdtc_sum_t;

    function automatic logic tdtc_hit
    (
        input logic [11:0] addr,
        input logic [7:0]  idx
    );
        return addr == {2'b00, idx, 2'b00};
    endfunction : tdtc_hit

endpackage : tdtc_pkg

// *** hdl/tdtc_dac_side.sv ***
`timescale 1ns/1ps
`include "tdtc_regs.svh"

module tdtc_dac_side
    import tdtc_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Steered byte load
    input  wire logic [2:0] load,
    input  wire tdtc_byte_t data,
    // Converter codes
    output tdtc_dac_t       hi_dac,
    output tdtc_dac_t       lo_dac,
    output tdtc_sum_t       sum
);

    // ****************************************************************
    // Storage registers: 0 low, 1 middle, 2 high
    // ****************************************************************
    tdtc_byte_t store [0:2];

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_store
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    store[g] <= 8'h00;
                else if (load[g])
                    store[g] <= data;         // [RULE_02] [RULE_18]
            end
        end
    endgenerate

    // ****************************************************************
    // Bit routing: middle byte splits across both DACs
    // ****************************************************************
    assign lo_dac = {store[1][3:0], store[0]};         // [RULE_06]
    assign hi_dac = {store[2], store[1][7:4]};         // [RULE_06]

    // Low MSB weighs as high bit 2
    wire tdtc_sum_t hi_w = {1'b0, hi_dac, 9'h000};
    wire tdtc_sum_t lo_w = {10'h000, lo_dac};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sum <= 22'h000000;
        else
            sum <= hi_w + lo_w;                         // [RULE_07]
    end

endmodule : tdtc_dac_side

// *** hdl/tdtc_top.sv ***
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "tdtc_regs.svh"

module tdtc_top
    import tdtc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Write-back comparators, high when preamp output above zero
    input  wire logic        comp_above_coarse,
    input  wire logic        comp_above_fine,
    // Coarse converter side
    output tdtc_dac_t        coarse_hi_dac,
    output tdtc_dac_t        coarse_lo_dac,
    output tdtc_sum_t        coarse_sum,
    output logic             coarse_track,
    // Fine converter side
    output tdtc_dac_t        fine_hi_dac,
    output tdtc_dac_t        fine_lo_dac,
    output tdtc_sum_t        fine_sum,
    output logic             fine_track,
    // Write-back enable to both comparators
    output logic             wb_enable,
    // Interrupt
    output logic             irq
);

    // ****************************************************************
    // Bus state
    // ****************************************************************
    tdtc_bus_state_t state;
    tdtc_bus_state_t next_state;

    tdtc_byte_t      steer;
    logic      [2:0] write_count;
    logic      [3:0] irq_status;
    logic      [3:0] irq_mask;
    logic            ccmp_prev;
    logic            fcmp_prev;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic hit_steer  = tdtc_hit(paddr, `TDTC_IDX_STEER);
    wire logic hit_data   = tdtc_hit(paddr, `TDTC_IDX_DATA);
    wire logic hit_wback  = tdtc_hit(paddr, `TDTC_IDX_WBACK);
    wire logic hit_status = tdtc_hit(paddr, `TDTC_IDX_STATUS);
    wire logic hit_istat  = tdtc_hit(paddr, `TDTC_IDX_IRQ_STAT);
    wire logic hit_imask  = tdtc_hit(paddr, `TDTC_IDX_IRQ_MASK);

    wire logic hit_any    = hit_steer | hit_data | hit_wback |
                            hit_status | hit_istat | hit_imask;

    // First access cycle prepares the answer, second one commits
    wire logic access     = psel & penable;
    wire logic start      = access & (state == TDTC_IDLE);
    wire logic commit     = access & (state == TDTC_ANSWER);
    wire logic wr_commit  = commit & pwrite & pstrb[0] & hit_any;

    wire logic wr_steer   = wr_commit & hit_steer;
    wire logic wr_data    = wr_commit & hit_data;
    wire logic wr_wback   = wr_commit & hit_wback;
    wire logic wr_istat   = wr_commit & hit_istat;
    wire logic wr_imask   = wr_commit & hit_imask;
    wire logic acc_wback  = commit & hit_wback;

    // ****************************************************************
    // Bus state machine
    // ****************************************************************
    always_comb
    begin
        case (state)
            TDTC_IDLE:
                next_state = start ? TDTC_ANSWER : TDTC_IDLE;
            TDTC_ANSWER:
                next_state = TDTC_IDLE;
            default:
                next_state = TDTC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= TDTC_IDLE;
        else
            state <= next_state;
    end

    // ****************************************************************
    // Steering register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            steer <= `TDTC_STEER_RST;
        else if (wr_steer)
            steer <= pwdata[7:0];                       // [RULE_01]
    end

    // Hold bit high means hold; track line high means track
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            coarse_track <= 1'b1;                       // [RULE_10]
            fine_track   <= 1'b1;                       // [RULE_10]
        end
        else if (wr_steer)
        begin
            coarse_track <= ~pwdata[`TDTC_ST_COARSE_HOLD]; // [RULE_04]
            fine_track   <= ~pwdata[`TDTC_ST_FINE_HOLD];   // [RULE_11]
        end
    end

    // ****************************************************************
    // Steering gates: active-low enables coincide with data strobe
    // ****************************************************************
    wire logic [2:0] fine_en   = ~steer[`TDTC_ST_FINE_HI:`TDTC_ST_FINE_LO];
    wire logic [2:0] coarse_en =
        ~steer[`TDTC_ST_COARSE_HI:`TDTC_ST_COARSE_LO];   // [RULE_14]

    wire logic [2:0] fine_load   = {3{wr_data}} & fine_en;   // [RULE_02]
    wire logic [2:0] coarse_load = {3{wr_data}} & coarse_en; // [RULE_15]

    wire logic any_load   = |{fine_load, coarse_load};
    wire logic data_ignored = wr_data & ~any_load;       // [RULE_18]

    // ****************************************************************
    // Converter sides
    // ****************************************************************
    tdtc_dac_side u_coarse
    (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (coarse_load),
        .data    (pwdata[7:0]),
        .hi_dac  (coarse_hi_dac),
        .lo_dac  (coarse_lo_dac),
        .sum     (coarse_sum)
    );

    tdtc_dac_side u_fine
    (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (fine_load),
        .data    (pwdata[7:0]),
        .hi_dac  (fine_hi_dac),
        .lo_dac  (fine_lo_dac),
        .sum     (fine_sum)
    );

    // ****************************************************************
    // Write-back enable
    // ****************************************************************
    // Any access at the write-back address enables the comparators;
    // a write with pstrb[0] set and bit 0 low turns them off again.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wb_enable <= `TDTC_WB_RST;
        else if (wr_wback)
            wb_enable <= pwdata[0];                     // [RULE_05]
        else if (acc_wback)
            wb_enable <= 1'b1;                          // [RULE_05]
    end

    wire logic ccmp_vis = wb_enable & comp_above_coarse; // [RULE_17]
    wire logic fcmp_vis = wb_enable & comp_above_fine;   // [RULE_17]

    // ****************************************************************
    // Update sequence counter
    // ****************************************************************
    wire logic cnt_full = (write_count == `TDTC_DATA_WRITES);
    wire logic upd_done = wr_data & any_load &
                          (write_count == `TDTC_DATA_WRITES - 3'h1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            write_count <= 3'h0;
        else if (wr_steer)
            write_count <= 3'h0;                        // [RULE_03]
        else if (wr_data && any_load && !cnt_full)
            write_count <= write_count + 3'h1;
    end

    // ****************************************************************
    // Comparator change detection
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ccmp_prev <= 1'b0;
            fcmp_prev <= 1'b0;
        end
        else
        begin
            ccmp_prev <= ccmp_vis;
            fcmp_prev <= fcmp_vis;
        end
    end

    wire logic ccmp_flip = wb_enable & (ccmp_vis ^ ccmp_prev); // [RULE_11]
    wire logic fcmp_flip = wb_enable & (fcmp_vis ^ fcmp_prev); // [RULE_11]

    // ****************************************************************
    // Interrupt status, mask and output
    // ****************************************************************
    wire logic [3:0] irq_event =
    {
        data_ignored,
        upd_done,
        fcmp_flip,
        ccmp_flip
    };

    wire logic [3:0] irq_clear = wr_istat ? pwdata[3:0] : 4'h0;

    // Event in the clear cycle wins
    wire logic [3:0] next_irq_status =
        (irq_status & ~irq_clear) | irq_event;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= `TDTC_IRQ_RST;
        else
            irq_status <= next_irq_status;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= `TDTC_IRQ_RST;
        else if (wr_imask)
            irq_mask <= pwdata[3:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(next_irq_status & irq_mask);
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire logic [7:0] status_word =
    {
        write_count,
        fine_track,
        coarse_track,
        wb_enable,
        fcmp_vis,
        ccmp_vis
    };

    wire logic [31:0] rd_mux =
        hit_status ? {24'h000000, status_word}      :
        hit_wback  ? {30'h00000000, fcmp_vis, ccmp_vis} :
        hit_istat  ? {28'h0000000, irq_status}      :
        hit_imask  ? {28'h0000000, irq_mask}        :
                     32'h00000000;

    // Answer prepared on the first access edge, held one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (start)
        begin
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pready  <= 1'b1;
            pslverr <= ~hit_any;
        end
        else
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ****************************************************************
    // Track path
    // ****************************************************************
    // While a side tracks, its summed code follows every stored byte
    // one clock later; in hold, the host approximates against the comparator
    // and sets the hold bit low again when done.
    // The track lines leave the block straight from their flops.

endmodule : tdtc_top

// *** testbench/tdtc_top_sva.sv ***
`timescale 1ns/1ps
module tdtc_chk
    import tdtc_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Converter
    input wire tdtc_dac_t   coarse_hi_dac,
    input wire tdtc_dac_t   coarse_lo_dac,
    input wire tdtc_sum_t   coarse_sum,
    input wire logic        coarse_track,
    input wire tdtc_dac_t   fine_hi_dac,
    input wire tdtc_dac_t   fine_lo_dac,
    input wire logic        fine_track,
    input wire logic        wb_enable
);
    // ********
    // Decode
    // ********
    wire        com  = psel && penable && pready;
    wire        wr   = com && pwrite && pstrb[0];
    wire        s_wr = wr && paddr == 12'h1c0;
    wire        d_wr = wr && paddr == 12'h1c4;
    wire        wb_a = com && paddr == 12'h200 && !(pwrite && !pstrb[0]);
    wire        wb_r = pready && paddr == 12'h200 && !pwrite;
    logic [7:0] steer;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            steer <= 8'h00;
        else if (s_wr)
            steer <= pwdata[7:0];

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_req;
        psel && penable && !pready;
    endsequence
    sequence s_ans;
        pready ##1 !pready;
    endsequence

    answer_slot_a: assert property (s_req |=> s_ans)
        else $error("answer not a single pulse after one wait");
    track_load_a: assert property (
        s_wr |=> coarse_track == !$past(pwdata[7])
            && fine_track == !$past(pwdata[3]))
        else $error("track lines differ from hold bits");
    track_keep_a: assert property (
        !s_wr |=> $stable(coarse_track) && $stable(fine_track))
        else $error("track line moved without steering write");
    wb_load_a: assert property (
        wb_a |=> wb_enable == (!$past(pwrite) || $past(pwdata[0])))
        else $error("write-back enable not loaded");
    lo_store_a: assert property (
        d_wr && !steer[4] |=> coarse_lo_dac[7:0] == $past(pwdata[7:0]))
        else $error("enabled low byte not stored");
    lo_keep_a: assert property (
        d_wr && steer[4] |=> $stable(coarse_lo_dac[7:0]))
        else $error("disabled low byte changed");
    hi_store_a: assert property (
        d_wr && !steer[6] |=> coarse_hi_dac[11:4] == $past(pwdata[7:0]))
        else $error("high byte not stored");
    mid_split_a: assert property (
        d_wr && !steer[1] |=>
            {fine_hi_dac[3:0], fine_lo_dac[11:8]} == $past(pwdata[7:0]))
        else $error("middle byte split wrong");
    sum_weight_a: assert property (
        1'b1 |=> coarse_sum == ({10'h0, $past(coarse_hi_dac)} << 9)
            + {10'h0, $past(coarse_lo_dac)})
        else $error("sum weighting wrong");
    wb_gate_a: assert property (
        wb_r && !$past(wb_enable) |-> prdata[1:0] == 2'b00)
        else $error("comparator readable while disabled");
endmodule : tdtc_chk

bind tdtc_top tdtc_chk u_tdtc_chk (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .coarse_hi_dac(coarse_hi_dac), .coarse_lo_dac(coarse_lo_dac),
    .coarse_sum(coarse_sum), .coarse_track(coarse_track),
    .fine_hi_dac(fine_hi_dac), .fine_lo_dac(fine_lo_dac),
    .fine_track(fine_track), .wb_enable(wb_enable));

// *** testbench/tdtc_track_model.sv ***
`timescale 1ns/1ps
module tdtc_track_model
    import tdtc_pkg::*;
(
    // Clock
    input  wire logic      pclk,
    // Converter side
    input  wire tdtc_sum_t sum,
    input  wire logic      track,
    input  wire logic      wb_enable,
    // Comparator, high when pair is above the held level
    output logic           above
);
    tdtc_sum_t held;

    initial above = 1'b0;

    // Integrator follows the pair in track and keeps it in hold
    // Disabled comparator output is meaningless, so it toggles
    always @(posedge pclk)
    begin
        if (track)
            held <= sum;
        above <= wb_enable ? (sum > held) : ~above;
    end
endmodule : tdtc_track_model

// *** testbench/tdtc_top_bench.sv ***
`timescale 1ns/1ps
`include "tdtc_regs.svh"
module tdtc_top_bench
    import tdtc_pkg::*;
;
    localparam logic [11:0] ST = {2'b00, `TDTC_IDX_STEER, 2'b00};
    localparam logic [11:0] DT = {2'b00, `TDTC_IDX_DATA, 2'b00};
    localparam logic [11:0] WB = {2'b00, `TDTC_IDX_WBACK, 2'b00};
    localparam logic [11:0] SR = {2'b00, `TDTC_IDX_STATUS, 2'b00};
    localparam logic [11:0] IS = {2'b00, `TDTC_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] MK = {2'b00, `TDTC_IDX_IRQ_MASK, 2'b00};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, irq, wb_enable, ctr, ftr, ca, fa, er;
    tdtc_dac_t   chi, clo, fhi, flo, lo, t;
    tdtc_sum_t   csum, fsum;
    logic [7:0]  e [6];
    logic [7:0]  v;
    int          miscompares = 0;
    int          checks = 0;

    always #10 pclk = ~pclk;

    tdtc_top u_tdtc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comp_above_coarse(ca), .comp_above_fine(fa), .coarse_hi_dac(chi),
        .coarse_lo_dac(clo), .coarse_sum(csum), .coarse_track(ctr),
        .fine_hi_dac(fhi), .fine_lo_dac(flo), .fine_sum(fsum),
        .fine_track(ftr), .wb_enable(wb_enable), .irq(irq));
    tdtc_track_model u_track_c (.pclk(pclk), .sum(csum), .track(ctr),
        .wb_enable(wb_enable), .above(ca));
    tdtc_track_model u_track_f (.pclk(pclk), .sum(fsum), .track(ftr),
        .wb_enable(wb_enable), .above(fa));

    // ********
    // Tasks
    // ********
    task automatic summarize();
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic ck(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask : ck

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 40)
        begin
            miscompares++;
            $display("[FAIL] %0t no answer", $time);
            summarize();
        end
    endtask : apb

    task automatic w(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d}, 4'hf);
    endtask : w

    task automatic r(input logic [11:0] a);
        apb(a, 1'b0, 32'h0, 4'h0);
    endtask : r

    task automatic dacs();
        @(posedge pclk);
        ck({8'h0, fhi, flo}, {8'h0, e[2], e[1], e[0]});
        ck({8'h0, chi, clo}, {8'h0, e[5], e[4], e[3]});
        ck({10'h0, fsum}, {e[2], e[1][7:4], 9'h0} + {e[1][3:0], e[0]});
        ck({10'h0, csum}, {e[5], e[4][7:4], 9'h0} + {e[4][3:0], e[3]});
    endtask : dacs

    // ********
    // Sequence
    // ********
    initial
    begin
        repeat (16) @(posedge pclk);
        ck({ctr, ftr, wb_enable, irq}, 4'hc);
        presetn <= 1'b1;
        @(posedge pclk);
        w(ST, 8'h00);
        w(DT, 8'hff);
        e = '{default: 8'hff};
        dacs();
        w(ST, 8'h33);
        w(DT, 8'h80);
        e[2] = 8'h80;
        e[5] = 8'h80;
        dacs();
        for (int k = 0; k < 6; k++)
        begin
            w(ST, 8'h77 & ~(8'h01 << (k < 3 ? k : k + 1)));
            e[k] = 8'h3c ^ 8'(k * 17);
            w(DT, e[k]);
            dacs();
        end
        for (int i = 0; i < 4; i++)
        begin
            v = {i[1], 3'h0, i[0], 3'h7};
            w(ST, v);
            ck({ctr, ftr}, {~v[7], ~v[3]});
            r(SR);
            ck(q[4:3], {~v[3], ~v[7]});
        end
        r(12'h300);
        ck(er, 1'b1);
        r(ST);
        ck({er, q[30:0]}, 32'h0);
        w(MK, 8'h04);
        w(ST, 8'h00);
        for (int k = 0; k < 6; k++)
            w(DT, 8'h00);
        e = '{default: 8'h00};
        r(SR);
        ck(q[7:5], 3'h6);
        r(IS);
        ck({irq, q[3:0]}, 5'h14);
        w(IS, 8'h04);
        r(IS);
        ck({irq, q[3:0]}, 5'h00);
        w(MK, 8'h00);
        w(ST, 8'h77);
        w(DT, 8'h99);
        r(IS);
        ck({irq, q[3:0]}, 5'h08);
        w(MK, 8'h08);
        r(IS);
        ck(irq, 1'b1);
        w(IS, 8'h08);
        r(IS);
        ck(irq, 1'b0);
        w(ST, 8'h00);
        apb(DT, 1'b1, 32'h5a, 4'he);
        dacs();
        w(WB, 8'h00);
        r(SR);
        ck({wb_enable, q[2:0]}, 4'h0);
        r(WB);
        ck(q[1:0], 2'b00);
        ck(wb_enable, 1'b1);
        w(ST, 8'h5f);
        w(DT, 8'h08);
        w(ST, 8'hdf);
        ck(ctr, 1'b0);
        w(DT, 8'h10);
        lo = 12'h000;
        for (int b = 11; b >= 0; b--)
        begin
            t = lo | (12'h001 << b);
            w(ST, 8'hdf);
            w(DT, {4'h1, t[11:8]});
            w(ST, 8'hef);
            w(DT, t[7:0]);
            repeat (4) @(posedge pclk);
            r(WB);
            if (q[0] === 1'b0)
                lo = t;
        end
        w(DT, lo[7:0]);
        w(ST, 8'h7f);
        repeat (2) @(posedge pclk);
        ck({chi, clo}, 24'h001600);
        ck({ctr, csum}, {1'b1, 22'd2048});
        summarize();
    end
endmodule : tdtc_top_bench
